//--- inc/vcal_pkg.sv
package vcal_pkg;
   localparam logic [15:0] VCAL_TRAVEL_CLOSE = 16'h0064; // 100 ticks
   localparam logic [15:0] VCAL_TRAVEL_OPEN = 16'h006E; // 110 ticks
   localparam logic [15:0] VCAL_TRAVEL_BOTH = 16'h0078; // 120 ticks
   localparam logic [15:0] VCAL_PULSE_LEN = 16'h001E; // 30 ticks
   localparam logic [15:0] VCAL_CRACK_TIME = 16'h0032; // 50 ticks
   localparam logic [15:0] VCAL_TICK_DIV = 16'h0019; // 25 clk per tick = 1 us
   localparam logic [31:0] VCAL_ADR_CTRL = 32'h0000_0000;
   localparam logic [31:0] VCAL_ADR_STAT = 32'h0000_0004;
   localparam logic [31:0] VCAL_ADR_IRQ = 32'h0000_0008;
   localparam logic [31:0] VCAL_ADR_MASK = 32'h0000_000C;
   localparam logic [31:0] VCAL_ADR_MAN = 32'h0000_0010;
   localparam logic [31:0] VCAL_CTRL_RST = 32'h0000_0000;

   typedef enum logic [1:0] {VCAL_CONF_CLOSE, VCAL_CONF_OPEN, VCAL_CONF_BOTH, VCAL_CONF_DBB}
      vcal_conf_t;
   typedef enum logic [1:0] {VCAL_ACT_SPRING, VCAL_ACT_BISTABLE, VCAL_ACT_MOTOR}
      vcal_act_t;

   // control register fields
   typedef struct packed {
      logic [19:0] spare;
      logic [3:0] manifold;
      logic interlockEn;
      logic selectorEn;
      logic [1:0] act;
      logic [1:0] conf;
      logic interlock;
      logic command;
   } vcal_ctrl_t;

   // drive outputs
   typedef struct packed {
      logic openDrive;
      logic closeDrive;
      logic motorFwd;
      logic motorRev;
      logic bleedDrive;
   } vcal_drive_t;
endpackage : vcal_pkg

//--- hdl/vcal_timer.sv
`timescale 1ns/1ps
`default_nettype none
module vcal_timer
   import vcal_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic pulseMode,
   input wire logic trig,
   input wire logic [15:0] preset,
   output logic q
);
   logic [15:0] count;
   logic trigLast;

   ////////////////////////////////////////////////////////////////
   // on-delay: q after trig held preset ticks; pulse: preset ticks per rise
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         count <= 16'h0000;
         q <= 1'b0;
         trigLast <= 1'b1; // no false edge from a trigger idling high
      end
      else if (!pulseMode)
      begin
         trigLast <= trig;
         if (!trig)
         begin
            count <= 16'h0000;
            q <= 1'b0;
         end
         else if (tick && count < preset)
            count <= count + 16'h0001;
         else if (count >= preset)
            q <= 1'b1;
      end
      else
      begin
         trigLast <= trig;
         if (trig && !trigLast && !q)
         begin
            q <= 1'b1;
            count <= 16'h0000;
         end
         else if (q && tick)
         begin
            count <= count + 16'h0001;
            if (count + 16'h0001 >= preset)
               q <= 1'b0;
         end
      end
   end
endmodule : vcal_timer
`default_nettype wire

//--- hdl/vcal_valve.sv
`timescale 1ns/1ps
`default_nettype none
module vcal_valve
   import vcal_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] fieldIn,
   output logic openDrive,
   output logic closeDrive,
   output logic motorFwd,
   output logic motorRev,
   output logic bleedDrive,
   output logic [3:0] manifoldDrive,
   output logic alarm,
   output logic irq
);
   vcal_ctrl_t ctrl;
   logic [7:0] inMeta;
   logic [7:0] inSync;
   logic [15:0] tickCnt;
   logic tick;
   logic effCmd;
   logic openReq;
   logic closeReq;
   logic alarmCond;
   logic [15:0] travel;
   logic travelAlarm;
   logic pulseOpen;
   logic pulseClose;
   logic crackFault;
   logic [15:0] crackCnt;
   logic crackArmed;
   logic effLast;
   logic [1:0] logicSlot;
   logic [3:0] irqStat;
   logic [3:0] irqMask;
   logic [3:0] events;
   logic alarmLast;
   logic interlockLast;
   logic [31:0] rdData;
   logic access;
   vcal_conf_t conf;
   vcal_act_t act;

   // decode one byte lane write
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
      input logic en);
      lane = en ? nw : old;
   endfunction : lane

   assign conf = vcal_conf_t'(ctrl.conf);
   assign act = vcal_act_t'(ctrl.act);
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

   ////////////////////////////////////////////////////////////////
   // field inputs through two flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         inMeta <= 8'h00;
         inSync <= 8'h00;
      end
      else
      begin
         inMeta <= fieldIn;
         inSync <= inMeta;
      end
   end

   // common timer tick
   always_ff @(posedge clk)
   begin
      if (sys_rst || tickCnt == VCAL_TICK_DIV - 16'h0001)
         tickCnt <= 16'h0000;
      else
         tickCnt <= tickCnt + 16'h0001;
   end
   assign tick = (tickCnt == VCAL_TICK_DIV - 16'h0001);

   ////////////////////////////////////////////////////////////////
   // effective command and drive requests
   always_comb
   begin
      effCmd = ctrl.command;
      if (ctrl.selectorEn)
         effCmd = (ctrl.command && !inSync[3]) || inSync[2];
      openReq = effCmd;
      closeReq = !effCmd;
      if (ctrl.interlockEn)
      begin
         openReq = effCmd && ctrl.interlock;
         closeReq = !effCmd || !ctrl.interlock;
      end
   end

   // alarm expression per confirm wiring, in1=open in2=close
   always_comb
   begin
      unique case (conf)
         VCAL_CONF_CLOSE:
         begin
            alarmCond = (!effCmd && !inSync[1]) || (effCmd && inSync[1]);
            travel = VCAL_TRAVEL_CLOSE;
         end
         VCAL_CONF_OPEN:
         begin
            alarmCond = (effCmd && !inSync[0]) || (!effCmd && inSync[0]);
            travel = VCAL_TRAVEL_OPEN;
         end
         VCAL_CONF_BOTH:
         begin
            alarmCond = (!effCmd && !inSync[1]) || (effCmd && !inSync[0])
               || (inSync[0] && inSync[1]);
            travel = VCAL_TRAVEL_BOTH;
         end
         VCAL_CONF_DBB:
         begin
            // close confirms on inputs 1..3 for V1, V2, bleed V3
            alarmCond = (!effCmd && (!inSync[0] || !inSync[1] || inSync[2]))
               || (effCmd && (inSync[0] || inSync[1] || !inSync[2]));
            travel = VCAL_TRAVEL_OPEN;
         end
      endcase
   end

   vcal_timer travelTimer (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .pulseMode(1'b0),
      .trig(alarmCond),
      .preset(travel),
      .q(travelAlarm)
   );

   vcal_timer openPulse (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .pulseMode(1'b1),
      .trig(openReq),
      .preset(VCAL_PULSE_LEN),
      .q(pulseOpen)
   );

   vcal_timer closePulse (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .pulseMode(1'b1),
      .trig(closeReq),
      .preset(VCAL_PULSE_LEN),
      .q(pulseClose)
   );

   ////////////////////////////////////////////////////////////////
   // crack time check for motor valve
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         crackCnt <= 16'h0000;
         crackArmed <= 1'b0;
         crackFault <= 1'b0;
         effLast <= 1'b0;
      end
      else
      begin
         effLast <= effCmd;
         if (act != VCAL_ACT_MOTOR)
         begin
            crackArmed <= 1'b0;
            crackFault <= 1'b0;
         end
         else if (effCmd != effLast)
         begin
            crackArmed <= 1'b1;
            crackCnt <= 16'h0000;
            crackFault <= 1'b0;
         end
         else if (crackArmed)
         begin
            // leaving closed needs close confirm to drop, and vice versa
            if ((effCmd && !inSync[1]) || (!effCmd && !inSync[0]))
               crackArmed <= 1'b0;
            else if (crackCnt >= VCAL_CRACK_TIME)
            begin
               crackFault <= 1'b1;
               crackArmed <= 1'b0;
            end
            else if (tick)
               crackCnt <= crackCnt + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // actuator drive flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         openDrive <= 1'b0;
         closeDrive <= 1'b0;
         motorFwd <= 1'b0;
         motorRev <= 1'b0;
         bleedDrive <= 1'b0;
      end
      else
      begin
         openDrive <= 1'b0;
         closeDrive <= 1'b0;
         motorFwd <= 1'b0;
         motorRev <= 1'b0;
         bleedDrive <= 1'b0;
         if (conf == VCAL_CONF_DBB)
         begin
            // bleed powered (shut) unless mains confirm closed and closing
            bleedDrive <= !(!openReq && inSync[0] && inSync[1]);
            openDrive <= openReq && inSync[2];
         end
         else
         begin
            unique case (act)
               VCAL_ACT_SPRING: openDrive <= openReq;
               VCAL_ACT_BISTABLE:
               begin
                  openDrive <= pulseOpen;
                  closeDrive <= pulseClose;
               end
               VCAL_ACT_MOTOR:
               begin
                  // run until the target confirm closes
                  motorFwd <= openReq && !inSync[0] && !crackFault;
                  motorRev <= closeReq && !inSync[1] && !crackFault;
               end
               default: openDrive <= 1'b0;
            endcase
         end
      end
   end

   // manifold valves each follow their own bit
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         manifoldDrive <= 4'h0;
      else
         manifoldDrive <= ctrl.manifold;
   end

   ////////////////////////////////////////////////////////////////
   // last expression slot holds alarm, reported to net block
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         logicSlot <= 2'b00;
         alarm <= 1'b0;
      end
      else
      begin
         logicSlot <= {crackFault, travelAlarm};
         alarm <= travelAlarm || crackFault;
      end
   end

   ////////////////////////////////////////////////////////////////
   // interrupt events: alarm rise, crack fault, interlock active, command edge
   always_comb
   begin
      events = {effCmd != effLast, ctrl.interlockEn && !ctrl.interlock && interlockLast,
         crackFault && !logicSlot[1], travelAlarm && !alarmLast};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irqStat <= 4'h0;
         alarmLast <= 1'b0;
         interlockLast <= 1'b0;
      end
      else
      begin
         alarmLast <= travelAlarm;
         interlockLast <= ctrl.interlock;
         if (access && !wb_we_i && wb_adr_i == VCAL_ADR_IRQ)
            irqStat <= events; // set wins over read clear
         else
            irqStat <= irqStat | events;
      end
   end
   assign irq = |(irqStat & irqMask);

   ////////////////////////////////////////////////////////////////
   // wishbone register writes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl <= VCAL_CTRL_RST;
         irqMask <= 4'h0;
      end
      else if (access && wb_we_i)
      begin
         if (wb_adr_i == VCAL_ADR_CTRL)
         begin
            ctrl[7:0] <= lane(ctrl[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            ctrl[11:8] <= 4'(lane({4'h0, ctrl[11:8]}, wb_dat_i[15:8], wb_sel_i[1]));
         end
         if (wb_adr_i == VCAL_ADR_MASK)
            irqMask <= 4'(lane({4'h0, irqMask}, wb_dat_i[7:0], wb_sel_i[0]));
      end
   end

   // read mux, unmapped reads zero
   always_comb
   begin
      unique case (wb_adr_i)
         VCAL_ADR_CTRL: rdData = {20'h0_0000, ctrl[11:0]};
         VCAL_ADR_STAT: rdData = {22'h00_0000, logicSlot, inSync};
         VCAL_ADR_IRQ: rdData = {28'h000_0000, irqStat};
         VCAL_ADR_MASK: rdData = {28'h000_0000, irqMask};
         VCAL_ADR_MAN: rdData = {24'h00_0000, 3'b000, openDrive, closeDrive, motorFwd,
            motorRev, bleedDrive};
         default: rdData = 32'h0000_0000;
      endcase
   end

   // one wait-free ack, data registered
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= access;
         wb_dat_o <= access ? rdData : 32'h0000_0000;
      end
   end
endmodule : vcal_valve
`default_nettype wire

//--- verification/vcal_valve_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vcal_valve_checker
   import vcal_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [7:0] fieldIn,
   input wire logic openDrive,
   input wire logic closeDrive,
   input wire logic [3:0] manifoldDrive,
   input wire logic alarm
);
   logic [11:0] ctrl;
   logic [11:0] hiCnt;
   logic spring;
   logic bist;
   ////////////////////////////////////////////////////////////////////////////////
   // mirror of accepted control writes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl <= 12'h000;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == VCAL_ADR_CTRL)
         ctrl <= wb_dat_i[11:0];
   end
   // cycles the open output has been high
   always_ff @(posedge clk)
   begin
      if (sys_rst || !openDrive)
         hiCnt <= 12'h000;
      else
         hiCnt <= hiCnt + 12'h001;
   end
   // plain mode decode
   assign spring = ctrl[5:4] == 2'h0 && ctrl[3:2] != 2'h3;
   assign bist = ctrl[5:4] == 2'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !openDrive && !closeDrive && !alarm)
      else $error("outputs active after reset");
   AST_SPRING_FOLLOW: assert property (spring && !ctrl[7] && !ctrl[6] && $changed(ctrl[0])
      |-> ##[1:4] openDrive == ctrl[0]) else $error("spring output off command");
   AST_INTERLOCK_SHUT: assert property ((spring && ctrl[7] && !ctrl[1])[*4] |-> !openDrive)
      else $error("open drive despite interlock");
   AST_SELECT_OPEN: assert property ((spring && ctrl[6] && !ctrl[7] && fieldIn[2])[*6]
      |-> openDrive) else $error("selector open ignored");
   AST_MANIFOLD: assert property ($stable(ctrl[11:8])[*4] |-> manifoldDrive == ctrl[11:8])
      else $error("manifold drive off control");
   AST_PULSE_LEN: assert property (bist && $fell(openDrive) |-> hiCnt > 12'h2BC && hiCnt < 12'h30C)
      else $error("open pulse length wrong");
endmodule : vcal_valve_checker
bind vcal_valve vcal_valve_checker chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .fieldIn(fieldIn), .openDrive(openDrive), .closeDrive(closeDrive),
   .manifoldDrive(manifoldDrive), .alarm(alarm));
`default_nettype wire

//--- verification/vcal_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module vcal_field_model
(
   input wire logic clk,
   input wire logic openDrive,
   input wire logic stuck,
   output logic [1:0] conf
);
   logic pos = 1'b0;
   logic [4:0] lag = 5'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // stem travels 20 cycles after drive, unless jammed
   always_ff @(posedge clk)
   begin
      if (openDrive == pos || stuck)
         lag <= 5'h00;
      else if (lag == 5'h13)
         pos <= openDrive;
      else
         lag <= lag + 5'h01;
   end
   // bit 0 open confirm, bit 1 close confirm
   assign conf = {!pos, pos};
endmodule : vcal_field_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import vcal_pkg::*;
   logic clk, sysRst, wbCyc, wbStb, wbWe, wbAck, stuck;
   logic openDrive, closeDrive, alarm, irq;
   logic motorFwd, motorRev, bleedDrive;
   logic [31:0] wbAdr, wbDat, wbDatO, rd;
   logic [3:0] manifoldDrive;
   logic [1:0] conf, selBits;
   logic [14:0] rows [7];
   int n_fail, tests_run, cycles;
   ////////////////////////////////////////////////////////////////////////////////
   vcal_valve DUT (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hF), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .fieldIn({4'h0, selBits, conf}), .openDrive(openDrive),
      .closeDrive(closeDrive), .motorFwd(motorFwd), .motorRev(motorRev),
      .bleedDrive(bleedDrive),
      .manifoldDrive(manifoldDrive), .alarm(alarm), .irq(irq));
   vcal_field_model field (.clk(clk), .openDrive(openDrive), .stuck(stuck), .conf(conf));
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task wb(input logic we, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      // only the cycle ceiling ends a wait for ack
      do
      begin
         @(posedge clk);
      end
      while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk32
   task chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask : chk1
   task report_and_stop;
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   // rows: control word, selector bits, expected open drive
   initial
   begin
      rows = '{{12'h001, 2'h0, 1'h1}, {12'h000, 2'h0, 1'h0}, {12'h081, 2'h0, 1'h0},
         {12'h083, 2'h0, 1'h1}, {12'h040, 2'h1, 1'h1}, {12'h041, 2'h2, 1'h0},
         {12'h501, 2'h0, 1'h1}};
      {wbCyc, wbStb, wbWe, stuck, selBits} = 6'h00;
      {wbAdr, wbDat} = 64'h0;
      sysRst = 1'b1;
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      wb(1'b1, VCAL_ADR_MASK, 32'h0000_0001);
      for (int i = 0; i < 7; i++)
      begin
         selBits <= rows[i][2:1];
         wb(1'b1, VCAL_ADR_CTRL, {20'h0_0000, rows[i][14:3]});
         repeat (10) @(posedge clk);
         chk1(openDrive, rows[i][0]);
         chk32({28'h0, manifoldDrive}, {28'h0, rows[i][14:11]});
         $display("row %0d done", i);
      end
      // jammed open valve commanded shut raises travel alarm
      repeat (30) @(posedge clk);
      stuck <= 1'b1;
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0000);
      repeat (2400) @(posedge clk);
      chk1(alarm, 1'b0);
      repeat (200) @(posedge clk);
      chk1(alarm, 1'b1);
      chk1(irq, 1'b1);
      wb(1'b0, VCAL_ADR_STAT, 32'h0);
      chk32(rd & 32'h0000_0100, 32'h0000_0100);
      wb(1'b0, VCAL_ADR_IRQ, 32'h0);
      chk32(rd & 32'h0000_0001, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0);
      wb(1'b0, 32'h0000_0020, 32'h0000_0000);
      chk32(rd, 32'h0000_0000);
      stuck <= 1'b0;
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0001);
      repeat (10) @(posedge clk);
      chk1(alarm, 1'b0);
      $display("alarm test done");
      // bistable pulses each way
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0010);
      repeat (800) @(posedge clk);
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0011);
      repeat (5) @(posedge clk);
      chk1(openDrive, 1'b1);
      repeat (800) @(posedge clk);
      chk1(openDrive, 1'b0);
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0010);
      repeat (5) @(posedge clk);
      chk1(closeDrive, 1'b1);
      $display("pulse test done");
      // reset in mid pulse
      sysRst <= 1'b1;
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      chk1(closeDrive, 1'b0);
      chk1(alarm, 1'b0);
      $display("reset test done");
      // motor drive, then crack fault with a jammed stem
      stuck <= 1'b1;
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0021);
      repeat (5) @(posedge clk);
      chk1(motorFwd, 1'b1);
      chk1(motorRev, 1'b0);
      repeat (1100) @(posedge clk);
      chk1(alarm, 1'b0);
      repeat (300) @(posedge clk);
      chk1(alarm, 1'b1);
      chk1(motorFwd, 1'b0);
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_0020);
      repeat (5) @(posedge clk);
      chk1(motorRev, 1'b0);
      chk1(alarm, 1'b0);
      $display("motor test done");
      // double block and bleed: mains wait for bleed shut confirm
      wb(1'b1, VCAL_ADR_CTRL, 32'h0000_000D);
      repeat (5) @(posedge clk);
      chk1(openDrive, 1'b0);
      chk1(bleedDrive, 1'b1);
      selBits <= 2'h1;
      repeat (5) @(posedge clk);
      chk1(openDrive, 1'b1);
      chk1(bleedDrive, 1'b1);
      $display("bleed test done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
